/* File: hdl/mp_startup_pkg.sv */
/*
  Constants for the multiprocessor start-up sequencer: register addresses,
  field positions, command encodings, reset values and id layouts.
  Assumes a 100 MHz core clock.
*/
package mp_startup_pkg;

  // register byte addresses
  localparam logic [31:0] ID_REG_ADDR       = 32'hFEE00020;
  localparam logic [31:0] SPUR_VEC_ADDR     = 32'hFEE000F0;
  localparam logic [31:0] CMD_LOW_ADDR      = 32'hFEE00300;
  localparam logic [31:0] ERR_VEC_ADDR      = 32'hFEE00370;

  // fields
  localparam int          CTRL_ENABLE_BIT   = 8;
  localparam logic [31:0] CONTROLLER_ENABLE_MASK = 32'h00000100;
  localparam logic [31:0] ID_FIELD_MASK     = 32'hFF000000;
  localparam int          ID_FIELD_LSB      = 24;
  localparam int          PAGE_SHIFT        = 12;

  // command encodings, low byte of startup is the page vector
  localparam logic [31:0] CMD_INIT_BCAST    = 32'h000C4500;
  localparam logic [23:0] CMD_STARTUP_HI    = 24'h000C46;

  // reset values
  localparam logic [31:0] SPUR_VEC_RESET    = 32'h00000000;
  localparam logic [31:0] ERR_VEC_RESET     = 32'h00010000;
  localparam logic [31:0] RESET_FETCH_ADDR  = 32'hFFFFFFF0;
  localparam logic [31:0] ADDR_RESET        = 32'h00000000;

  // id layouts
  localparam int          THREAD_BIT        = 0;
  localparam int          NEW_SOCKET_LSB    = 1;
  localparam int          NEW_CLUSTER_LSB   = 3;
  localparam int          OLD_SOCKET_LSB    = 0;
  localparam int          OLD_CLUSTER_LSB   = 2;

  typedef enum logic [1:0] {ROLE_RESET, ROLE_BOOT, ROLE_WAIT_START, ROLE_HALTED} role_t;

endpackage : mp_startup_pkg

/* File: hdl/mp_startup_ipi_sequencer.sv */
/*
  Per-processor start-up logic: local controller register window (id,
  spurious vector, command low word, error vector entry), boot/helper role
  and fetch address selection, reaction to init and startup messages.
  Assumes the shared system bus delivers decoded messages as one-cycle
  pulses on this clock, and that software drives the documented sequence.
*/
`timescale 1ns/1ps
`default_nettype none
module mp_startup_ipi_sequencer
  import mp_startup_pkg::*;
#(
  parameter bit NEW_FAMILY   = 1'b1,
  parameter bit MULTI_THREAD = 1'b1
)(
  // clock and reset
  input  wire  logic        clock_in,
  input  wire  logic        rst_b_in,
  // straps and election, from pins
  input  wire  logic [7:0]  id_strap_in,
  input  wire  logic        elected_boot_in,
  input  wire  logic        election_done_in,
  // register access
  input  wire  logic        reg_wr_in,
  input  wire  logic        reg_rd_in,
  input  wire  logic [31:0] reg_addr_in,
  input  wire  logic [31:0] reg_wdata_in,
  output var   logic [31:0] reg_rdata_out,
  // messages from the shared bus
  input  wire  logic        init_msg_in,
  input  wire  logic        startup_msg_in,
  input  wire  logic [7:0]  startup_vec_in,
  input  wire  logic        halt_exec_in,
  // message out to the shared bus
  output var   logic        msg_send_out,
  output var   logic [31:0] msg_cmd_out,
  // core control
  output var   logic        fetch_start_out,
  output var   logic [31:0] fetch_addr_out,
  output var   logic        boot_flag_out,
  output var   logic        ctrl_enabled_out,
  output var   logic        halted_out
);

  // pin inputs through two flops each
  logic [7:0] strap_s1_ff, strap_s2_ff;
  logic       elect_s1_ff, elect_s2_ff, done_s1_ff, done_s2_ff;
  always_ff @(posedge clock_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      strap_s1_ff <= 8'h00;
      strap_s2_ff <= 8'h00;
      elect_s1_ff <= 1'b0;
      elect_s2_ff <= 1'b0;
      done_s1_ff  <= 1'b0;
      done_s2_ff  <= 1'b0;
    end
    else
    begin
      strap_s1_ff <= id_strap_in;
      strap_s2_ff <= strap_s1_ff;
      elect_s1_ff <= elected_boot_in;
      elect_s2_ff <= elect_s1_ff;
      done_s1_ff  <= election_done_in;
      done_s2_ff  <= done_s1_ff;
    end

  // id latched once after election settles; layout depends on family
  logic [7:0] id_ff;
  logic [7:0] nxt_id;
  always_comb
  begin
    if (NEW_FAMILY)
    begin
      nxt_id = {3'h0, strap_s2_ff[4:0]};
      if (!MULTI_THREAD)
        nxt_id[THREAD_BIT] = 1'b0;
    end
    else
      nxt_id = {4'h0, strap_s2_ff[3:0]};
  end

  role_t role_ff;
  logic  boot_flag_ff;
  always_ff @(posedge clock_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      role_ff      <= ROLE_RESET;
      boot_flag_ff <= 1'b0;
      id_ff        <= 8'h00;
    end
    else
    begin
      unique case (role_ff)
        ROLE_RESET:
          if (done_s2_ff)
          begin
            id_ff        <= nxt_id;
            boot_flag_ff <= elect_s2_ff;
            role_ff      <= elect_s2_ff ? ROLE_BOOT : ROLE_WAIT_START;
          end
        ROLE_BOOT:
          role_ff <= ROLE_BOOT;
        ROLE_WAIT_START:
          if (startup_msg_in)
            role_ff <= ROLE_BOOT;
        ROLE_HALTED:
          if (init_msg_in)
            role_ff <= ROLE_WAIT_START;
      endcase
      if (role_ff == ROLE_BOOT && !boot_flag_ff && halt_exec_in)
        role_ff <= ROLE_HALTED;
      if (init_msg_in && !boot_flag_ff && role_ff == ROLE_BOOT)
        role_ff <= ROLE_WAIT_START;
    end

  // fetch start pulse and address
  always_ff @(posedge clock_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      fetch_start_out <= 1'b0;
      fetch_addr_out  <= ADDR_RESET;
    end
    else
    begin
      fetch_start_out <= 1'b0;
      if (role_ff == ROLE_RESET && done_s2_ff && elect_s2_ff)
      begin
        fetch_start_out <= 1'b1;
        fetch_addr_out  <= RESET_FETCH_ADDR;
      end
      else if (role_ff == ROLE_WAIT_START && startup_msg_in)
      begin
        fetch_start_out <= 1'b1;
        fetch_addr_out  <= {12'h000, startup_vec_in, 12'h000};
      end
    end

  // registers
  logic [31:0] spur_vec_ff, cmd_low_ff, err_vec_ff;
  always_ff @(posedge clock_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      spur_vec_ff  <= SPUR_VEC_RESET;
      cmd_low_ff   <= 32'h00000000;
      err_vec_ff   <= ERR_VEC_RESET;
      msg_send_out <= 1'b0;
      msg_cmd_out  <= 32'h00000000;
    end
    else
    begin
      msg_send_out <= 1'b0;
      if (reg_wr_in)
        unique case (reg_addr_in)
          SPUR_VEC_ADDR: spur_vec_ff <= reg_wdata_in;
          ERR_VEC_ADDR:  err_vec_ff  <= reg_wdata_in;
          CMD_LOW_ADDR:
          begin
            cmd_low_ff <= reg_wdata_in;
            // a disabled controller sends nothing
            if (spur_vec_ff[CTRL_ENABLE_BIT])
            begin
              msg_send_out <= 1'b1;
              msg_cmd_out  <= reg_wdata_in;
            end
          end
          default: ;
        endcase
      if (init_msg_in && !boot_flag_ff)
        spur_vec_ff <= SPUR_VEC_RESET;
    end

  always_ff @(posedge clock_in or negedge rst_b_in)
    if (!rst_b_in)
      reg_rdata_out <= 32'h00000000;
    else if (reg_rd_in)
      unique case (reg_addr_in)
        ID_REG_ADDR:   reg_rdata_out <= {id_ff, 24'h000000} & ID_FIELD_MASK;
        SPUR_VEC_ADDR: reg_rdata_out <= spur_vec_ff;
        CMD_LOW_ADDR:  reg_rdata_out <= cmd_low_ff;
        ERR_VEC_ADDR:  reg_rdata_out <= err_vec_ff;
        default:       reg_rdata_out <= 32'h00000000;
      endcase

  always_ff @(posedge clock_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      boot_flag_out    <= 1'b0;
      ctrl_enabled_out <= 1'b0;
      halted_out       <= 1'b0;
    end
    else
    begin
      boot_flag_out    <= boot_flag_ff;
      ctrl_enabled_out <= spur_vec_ff[CTRL_ENABLE_BIT];
      halted_out       <= (role_ff == ROLE_HALTED);
    end

  // checks
  enable_track_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    ##1 ctrl_enabled_out == $past(spur_vec_ff[CTRL_ENABLE_BIT]))
    else $error("enable output does not follow bit 8");
  boot_fetch_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (role_ff == ROLE_RESET && done_s2_ff && elect_s2_ff) |=>
      fetch_start_out && fetch_addr_out == RESET_FETCH_ADDR)
    else $error("boot fetch address wrong");
  helper_fetch_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (role_ff == ROLE_WAIT_START && startup_msg_in) |=>
      fetch_addr_out == {12'h000, $past(startup_vec_in), 12'h000})
    else $error("helper fetch address wrong");
  helper_start_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (role_ff == ROLE_WAIT_START && startup_msg_in) |=> role_ff == ROLE_BOOT)
    else $error("helper did not start");
  halt_hold_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (role_ff == ROLE_HALTED && !init_msg_in) |=> role_ff == ROLE_HALTED)
    else $error("helper left halt without init");
  id_read_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (reg_rd_in && reg_addr_in == ID_REG_ADDR) |=> reg_rdata_out[23:0] == 24'h000000
      && reg_rdata_out[31:24] == $past(id_ff))
    else $error("id register read wrong");
  id_layout_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    NEW_FAMILY ? id_ff[7:5] == 3'h0 : id_ff[7:4] == 4'h0)
    else $error("id wider than family layout");
  thread_bit_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (NEW_FAMILY && !MULTI_THREAD) |-> !id_ff[THREAD_BIT])
    else $error("thread bit set without multithreading");
  helper_flag_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (role_ff == ROLE_WAIT_START) |-> !boot_flag_ff)
    else $error("waiting helper has boot flag");

  boot_c: cover property (@(posedge clock_in) disable iff (!rst_b_in)
    role_ff == ROLE_RESET ##1 role_ff == ROLE_BOOT && boot_flag_ff);
  helper_c: cover property (@(posedge clock_in) disable iff (!rst_b_in)
    role_ff == ROLE_WAIT_START && startup_msg_in);
  halt_c: cover property (@(posedge clock_in) disable iff (!rst_b_in)
    role_ff == ROLE_HALTED && init_msg_in);
  send_c: cover property (@(posedge clock_in) disable iff (!rst_b_in)
    msg_send_out && msg_cmd_out == CMD_INIT_BCAST);

endmodule : mp_startup_ipi_sequencer
`default_nettype wire

/* File: tb/far_side_model.sv */
/*
  Far-side model: the other processors and their software on the shared bus.
  Assumes the bench calls its tasks; all pulses change at the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module far_side_model
#(
  // scaled gaps; real software waits 10 ms and 200 us
  parameter int INIT_GAP  = 100,
  parameter int START_GAP = 20
)(
  // clock
  input  wire logic       clock_in,
  // messages toward the block
  output var  logic       init_msg_out,
  output var  logic       startup_msg_out,
  output var  logic [7:0] startup_vec_out,
  output var  logic       halt_exec_out
);
  int         tally          = 0;
  logic [7:0] init_lock      = 8'h00;
  // bookkeeping of what the far software keeps; the model sends no interrupts
  logic       ctrl_range_uc  = 1'b0;
  logic       intr_held      = 1'b0;
  int         mgmt_mode_base = 0;

  initial
  begin
    init_msg_out    = 1'b0;
    startup_msg_out = 1'b0;
    startup_vec_out = 8'h5A;
    halt_exec_out   = 1'b0;
  end

  task automatic pulse_msg(input logic is_init, input logic [7:0] vec);
    @(negedge clock_in);
    init_msg_out    = is_init;
    startup_msg_out = !is_init;
    startup_vec_out = vec;
    @(negedge clock_in);
    init_msg_out    = 1'b0;
    startup_msg_out = 1'b0;
    // released bus must not keep showing the vector
    startup_vec_out = ~vec;
  endtask : pulse_msg

  task automatic wake_helpers(input logic [7:0] vec);
    tally         = 1;
    init_lock     = 8'h00;
    ctrl_range_uc = 1'b1;
    intr_held     = 1'b1;
    pulse_msg(1'b1, 8'h00);
    repeat (INIT_GAP) @(negedge clock_in);
    repeat (2)
    begin
      pulse_msg(1'b0, vec);
      repeat (START_GAP) @(negedge clock_in);
    end
    intr_held = 1'b0;
  endtask : wake_helpers

  task automatic helper_software;
    wait (init_lock == 8'h00);
    init_lock      = 8'h01;
    tally          = tally + 1;
    // each processor's handler base follows its arrival order
    mgmt_mode_base = tally;
    init_lock = 8'h00;
    @(negedge clock_in);
    halt_exec_out = 1'b1;
    @(negedge clock_in);
    halt_exec_out = 1'b0;
  endtask : helper_software
endmodule : far_side_model
`default_nettype wire

/* File: tb/mp_startup_ipi_sequencer_bench.sv */
/*
  Bench for the start-up sequencer: registers, sending, roles, fetch.
  Assumes far_side_model drives the incoming message pins.
*/
`timescale 1ns/1ps
`default_nettype none
module mp_startup_ipi_sequencer_bench;
  import mp_startup_pkg::*;
  logic        clock_in  = 1'b0;
  logic        rst_b_in  = 1'b0;
  logic [7:0]  id_strap  = 8'h00;
  logic        elected   = 1'b0;
  logic        done      = 1'b0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [31:0] reg_addr  = 32'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] rdata, cmd, faddr;
  logic [31:0] rdata_old, rdata_st;
  logic        init_msg, su_msg, halt_exec, send, fstart, boot_flag, ctrl_en, halted;
  logic [7:0]  su_vec;
  int          errors      = 0;
  int          check_count = 0;
  int          fetch_count = 0;

  mp_startup_ipi_sequencer u_dut (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .id_strap_in(id_strap), .elected_boot_in(elected), .election_done_in(done),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_rdata_out(rdata), .init_msg_in(init_msg),
    .startup_msg_in(su_msg), .startup_vec_in(su_vec), .halt_exec_in(halt_exec),
    .msg_send_out(send), .msg_cmd_out(cmd), .fetch_start_out(fstart),
    .fetch_addr_out(faddr), .boot_flag_out(boot_flag), .ctrl_enabled_out(ctrl_en),
    .halted_out(halted));

  // older id layout, and a newer part without multithreading
  mp_startup_ipi_sequencer #(.NEW_FAMILY(1'b0), .MULTI_THREAD(1'b1)) u_dut_old (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .id_strap_in(id_strap),
    .elected_boot_in(elected), .election_done_in(done), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_rdata_out(rdata_old), .init_msg_in(init_msg), .startup_msg_in(su_msg),
    .startup_vec_in(su_vec), .halt_exec_in(halt_exec), .msg_send_out(),
    .msg_cmd_out(), .fetch_start_out(), .fetch_addr_out(), .boot_flag_out(),
    .ctrl_enabled_out(), .halted_out());

  mp_startup_ipi_sequencer #(.NEW_FAMILY(1'b1), .MULTI_THREAD(1'b0)) u_dut_st (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .id_strap_in(id_strap),
    .elected_boot_in(elected), .election_done_in(done), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_rdata_out(rdata_st), .init_msg_in(init_msg), .startup_msg_in(su_msg),
    .startup_vec_in(su_vec), .halt_exec_in(halt_exec), .msg_send_out(),
    .msg_cmd_out(), .fetch_start_out(), .fetch_addr_out(), .boot_flag_out(),
    .ctrl_enabled_out(), .halted_out());

  far_side_model u_far (.clock_in(clock_in), .init_msg_out(init_msg),
    .startup_msg_out(su_msg), .startup_vec_out(su_vec), .halt_exec_out(halt_exec));

  always #5 clock_in = ~clock_in;

  always @(posedge clock_in)
    if (fstart === 1'b1)
      fetch_count <= fetch_count + 1;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic reg_access(input logic wr, input logic [31:0] addr, input logic [31:0] data);
    @(negedge clock_in);
    reg_wr    = wr;
    reg_rd    = !wr;
    reg_addr  = addr;
    reg_wdata = data;
    @(negedge clock_in);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask : reg_access

  task automatic do_reset(input logic boot, input logic [7:0] strap);
    @(negedge clock_in);
    rst_b_in = 1'b0;
    elected  = boot;
    done     = 1'b0;
    id_strap = strap;
    repeat (12) @(negedge clock_in);
    rst_b_in = 1'b1;
    repeat (4) @(negedge clock_in);
  endtask : do_reset

  task automatic t_regs;
    check(ctrl_en, 1'b0);
    reg_access(1'b0, SPUR_VEC_ADDR, 32'h0);
    check(rdata, 32'h0);
    reg_access(1'b1, ID_REG_ADDR, 32'h0);
    reg_access(1'b0, ID_REG_ADDR, 32'h0);
    // id is latched only once election is done
    check(rdata, 32'h00000000);
    reg_access(1'b0, 32'hFEE00400, 32'h0);
    check(rdata, 32'h0);
    reg_access(1'b0, ERR_VEC_ADDR, 32'h0);
    check(rdata, ERR_VEC_RESET);
    reg_access(1'b1, ERR_VEC_ADDR, 32'h000000FE);
    reg_access(1'b0, ERR_VEC_ADDR, 32'h0);
    check(rdata, 32'h000000FE);
  endtask : t_regs

  task automatic t_send;
    reg_access(1'b1, CMD_LOW_ADDR, 32'h000C4500);
    check(send, 1'b0);
    reg_access(1'b1, SPUR_VEC_ADDR, 32'h00000100);
    @(negedge clock_in);
    check(ctrl_en, 1'b1);
    reg_access(1'b1, CMD_LOW_ADDR, 32'h000C4500);
    check(send, 1'b1);
    check(cmd, 32'h000C4500);
    reg_access(1'b1, CMD_LOW_ADDR, 32'h000C46BD);
    check(cmd, 32'h000C46BD);
    @(negedge clock_in);
    check(send, 1'b0);
  endtask : t_send

  task automatic t_helper;
    int base;
    base = fetch_count;
    done = 1'b1;
    repeat (8) @(negedge clock_in);
    check(boot_flag, 1'b0);
    check(fetch_count - base, 0);
    reg_access(1'b0, ID_REG_ADDR, 32'h0);
    check(rdata, 32'h1F000000);
    check(rdata_old, 32'h0F000000);
    check(rdata_st, 32'h1E000000);
    u_far.wake_helpers(8'hBD);
    // init resets the helper's spurious vector register, so its controller is disabled
    check(ctrl_en, 1'b0);
    check(fetch_count - base, 1);
    check(faddr, 32'h000BD000);
    u_far.helper_software();
    check(u_far.tally, 2);
    @(negedge clock_in);
    check(halted, 1'b1);
    u_far.pulse_msg(1'b0, 8'h22);
    @(negedge clock_in);
    check(fetch_count - base, 1);
    u_far.pulse_msg(1'b1, 8'h00);
    @(negedge clock_in);
    check(halted, 1'b0);
    u_far.pulse_msg(1'b0, 8'hFF);
    @(negedge clock_in);
    check(fetch_count - base, 2);
    check(faddr, 32'h000FF000);
  endtask : t_helper

  task automatic t_boot;
    int base;
    do_reset(1'b1, 8'h00);
    base = fetch_count;
    done = 1'b1;
    repeat (8) @(negedge clock_in);
    check(fetch_count - base, 1);
    check(faddr, 32'hFFFFFFF0);
    check(boot_flag, 1'b1);
    u_far.pulse_msg(1'b0, 8'h10);
    @(negedge clock_in);
    check(fetch_count - base, 1);
    reg_access(1'b0, ID_REG_ADDR, 32'h0);
    check(rdata, 32'h0);
  endtask : t_boot

  task automatic test_done;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  initial
  begin
    #50000;
    errors++;
    test_done();
  end

  initial
  begin
    do_reset(1'b0, 8'hFF);
    t_regs();
    t_send();
    t_helper();
    t_boot();
    test_done();
  end
endmodule : mp_startup_ipi_sequencer_bench
`default_nettype wire
